// *** vref_tsense_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef VREF_TSENSE_MAP_SVH
`define VREF_TSENSE_MAP_SVH

`define VREF_CTRL_OFS 12'h000
`define VREF_IRQ_STAT_OFS 12'h004
`define VREF_IRQ_MASK_OFS 12'h008
`define VREF_CTRL_RESET 8'h00
`define VREF_BIT_ENABLE 7
`define VREF_BIT_READY 6
`define VREF_BIT_TS_EN 5
`define VREF_BIT_TS_RNG 4
`define VREF_FLD_CMP_LO 2
`define VREF_FLD_CONV_LO 0
`define VREF_SETTLE_NS 20000
`define VREF_CLK_NS 4
`define VREF_SETTLE_CYC ((`VREF_SETTLE_NS + `VREF_CLK_NS - 1) / `VREF_CLK_NS)

`endif

// *** vref_tsense_pkg.sv ***
// types shared by the reference and temperature sensor control logic
package vref_tsense_pkg;

  typedef enum logic [1:0]
  {
    gain_off = 2'h0,
    gain_x1 = 2'h1,
    gain_x2 = 2'h2,
    gain_x4 = 2'h3
  } gain_sel_t;

  typedef struct packed
  {
    logic ref_enable;
    logic temp_sense_enable;
    logic temp_range_select;
    gain_sel_t cmp_dac_gain_select;
    gain_sel_t conv_gain_select;
  } analog_ctrl_t;

  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed
  {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [2:0]
  {
    st_off = 3'h1,
    st_settle = 3'h2,
    st_ready = 3'h4
  } settle_state_t;

endpackage : vref_tsense_pkg

// *** vref_settle.sv ***
// stabilisation timer that raises the ready flag after enable
`include "vref_tsense_map.svh"

module vref_settle
#(
  parameter int SETTLE_CYC = `VREF_SETTLE_CYC
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enable,
  output logic ready
);
  import vref_tsense_pkg::*;

  // the counter is 16 bits; a longer wait would be cut to 16 bits and finish early
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
  begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  typedef struct packed
  {
    settle_state_t st;
    logic [15:0] cnt;
  } settle_reg_t;

  settle_reg_t cur;
  settle_reg_t next_cur;

  always_comb
  begin
    next_cur = cur;
    case (cur.st)
      st_off:
      begin
        next_cur.cnt = 16'h0000;
        if (enable)
          next_cur.st = st_settle;
      end
      st_settle:
      begin
        if (!enable)
          next_cur.st = st_off;
        else if (cur.cnt == 16'(SETTLE_CYC - 1))
          next_cur.st = st_ready;
        else
          next_cur.cnt = cur.cnt + 16'h0001;
      end
      st_ready:
      begin
        if (!enable)
          next_cur.st = st_off;
      end
      default:
        next_cur.st = st_off;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cur.st <= st_off;
      cur.cnt <= 16'h0000;
    end
    else
      cur <= next_cur;
  end

  // ready drops at once with enable, before the state catches up
  assign ready = enable && (cur.st == st_ready);

  chk_ready_after_settle: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(ready) |-> cur.cnt == 16'(SETTLE_CYC - 1))
    else $error("ready rose before settle count");

endmodule : vref_settle

// *** vref_tsense_ctrl.sv ***
// apb register bank for the fixed reference and temperature indicator
//
// Design decisions made here: the register offsets and register access over APB.
`include "vref_tsense_map.svh"

// Overview of operation
// - Bit 7 of the control register turns the fixed reference on or off.
// - Read-only bit 6 is one only while the enabled reference is ready.
// - On the higher-voltage variant the ready bit always reads one.
// - Bit 5 enables the temperature indicator circuit.
// - Bit 4 picks the indicator range, one high and zero low.
// - Bits 3-2 set the comparator, DAC and sense path gain: off,1x,2x,4x.
// - Bits 1-0 set the converter path gain: off, 1x, 2x, 4x.
// - Ready sets only after the reference circuits have settled.
module vref_tsense_ctrl
#(
  parameter bit HIGH_VDD_VARIANT = 1'b0,
  parameter int SETTLE_CYC = `VREF_SETTLE_CYC
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire vref_tsense_pkg::apb_req_t apb_req,
  output vref_tsense_pkg::apb_rsp_t apb_rsp,
  output vref_tsense_pkg::analog_ctrl_t analog_ctrl,
  output logic ref_ready,
  output logic irq
);
  import vref_tsense_pkg::*;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed
  {
    analog_ctrl_t ctrl;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic ready_q;
    logic [31:0] prdata;
  } bank_t;

  bank_t cur;
  bank_t next_cur;
  logic settle_ready;
  logic ready_bit;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic [1:0] events;
  logic wait_q;

  function automatic logic [7:0] pack_ctrl(input analog_ctrl_t c,
                                           input logic rdy);
    logic [7:0] v;
    v = 8'h00;
    v[`VREF_BIT_ENABLE] = c.ref_enable;
    v[`VREF_BIT_READY] = rdy;
    v[`VREF_BIT_TS_EN] = c.temp_sense_enable;
    v[`VREF_BIT_TS_RNG] = c.temp_range_select;
    v[`VREF_FLD_CMP_LO +: 2] = c.cmp_dac_gain_select;
    v[`VREF_FLD_CONV_LO +: 2] = c.conv_gain_select;
    return v;
  endfunction : pack_ctrl

  // --------------------------------------------------------------
  // settling timer
  // --------------------------------------------------------------
  // the timer counts in 16 bits; a longer wait would be cut to 16 bits and end early
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535)
  begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  vref_settle #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_settle (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(cur.ctrl.ref_enable),
    .ready(settle_ready)
  );

  // the high-supply part has its reference always ready
  assign ready_bit = HIGH_VDD_VARIANT ? 1'b1 : settle_ready;
  assign ref_ready = ready_bit;

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  // a write lands only at the edge where pready is seen, so a one-to-clear
  // is applied once and wipes an event raised a cycle earlier, but not one raised at that edge
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite &&
    wait_q;
  assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;

  always_comb
  begin
    if (apb_req.paddr == `VREF_CTRL_OFS)
      addr_ok = 1'b1;
    else if (apb_req.paddr == `VREF_IRQ_STAT_OFS)
      addr_ok = 1'b1;
    else if (apb_req.paddr == `VREF_IRQ_MASK_OFS)
      addr_ok = 1'b1;
    else
      addr_ok = 1'b0;
  end

  // event 0: ready rose, event 1: ready fell
  assign events = {cur.ready_q && !ready_bit, !cur.ready_q && ready_bit};

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.ready_q = ready_bit;
    if (wr_acc)
    begin
      if (apb_req.paddr == `VREF_CTRL_OFS)
      begin
        // bit 6 is not stored, so a write cannot touch it
        next_cur.ctrl.ref_enable =
          apb_req.pwdata[`VREF_BIT_ENABLE];
        next_cur.ctrl.temp_sense_enable =
          apb_req.pwdata[`VREF_BIT_TS_EN];
        next_cur.ctrl.temp_range_select =
          apb_req.pwdata[`VREF_BIT_TS_RNG];
        next_cur.ctrl.cmp_dac_gain_select =
          gain_sel_t'(apb_req.pwdata[`VREF_FLD_CMP_LO +: 2]);
        next_cur.ctrl.conv_gain_select =
          gain_sel_t'(apb_req.pwdata[`VREF_FLD_CONV_LO +: 2]);
      end
      else if (apb_req.paddr == `VREF_IRQ_STAT_OFS)
        next_cur.irq_stat = cur.irq_stat & ~apb_req.pwdata[1:0];
      else if (apb_req.paddr == `VREF_IRQ_MASK_OFS)
        next_cur.irq_mask = apb_req.pwdata[1:0];
    end
    // set beats a clear in the same cycle
    next_cur.irq_stat = next_cur.irq_stat | events;
    next_cur.prdata = 32'h0000_0000;
    if (rd_acc)
    begin
      if (apb_req.paddr == `VREF_CTRL_OFS)
        next_cur.prdata = {24'h00_0000, pack_ctrl(cur.ctrl, ready_bit)};
      else if (apb_req.paddr == `VREF_IRQ_STAT_OFS)
        next_cur.prdata = {30'h0000_0000, cur.irq_stat};
      else if (apb_req.paddr == `VREF_IRQ_MASK_OFS)
        next_cur.prdata = {30'h0000_0000, cur.irq_mask};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cur.ctrl <= analog_ctrl_t'(7'h00);
      cur.irq_stat <= 2'h0;
      cur.irq_mask <= 2'h0;
      // idle level of the flag, so no false edge follows reset
      cur.ready_q <= HIGH_VDD_VARIANT;
      cur.prdata <= 32'h0000_0000;
    end
    else
      cur <= next_cur;
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // read data is registered, so the access phase takes two cycles
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      wait_q <= 1'b0;
    else
      wait_q <= apb_req.psel && apb_req.penable && !wait_q;
  end

  // reads and writes share the same two-cycle answer for simplicity
  assign apb_rsp.pready = wait_q;
  assign apb_rsp.pslverr = wait_q && !addr_ok;
  assign apb_rsp.prdata = cur.prdata;
  assign analog_ctrl = cur.ctrl;
  assign irq = |(cur.irq_stat & cur.irq_mask);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  chk_enable_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_acc && apb_req.paddr == `VREF_CTRL_OFS |=>
      analog_ctrl.ref_enable ==
        $past(apb_req.pwdata[`VREF_BIT_ENABLE]))
    else $error("reference enable not taken from write");

  chk_ready_needs_en: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !HIGH_VDD_VARIANT && !analog_ctrl.ref_enable |-> !ref_ready)
    else $error("ready while reference disabled");

  chk_ready_variant: assert property (
    @(posedge mclk) disable iff (sys_rst)
    HIGH_VDD_VARIANT |-> ref_ready)
    else $error("high variant ready not one");

  // the always-ready part must never log a ready edge, not even at reset
  chk_variant_quiet: assert property (
    @(posedge mclk) disable iff (sys_rst)
    HIGH_VDD_VARIANT |-> cur.irq_stat == 2'h0)
    else $error("high variant raised a ready event");

  chk_tsense_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_acc && apb_req.paddr == `VREF_CTRL_OFS |=>
      analog_ctrl.temp_sense_enable ==
        $past(apb_req.pwdata[`VREF_BIT_TS_EN]))
    else $error("sensor enable not taken");

  chk_range_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_acc && apb_req.paddr == `VREF_CTRL_OFS |=>
      analog_ctrl.temp_range_select ==
        $past(apb_req.pwdata[`VREF_BIT_TS_RNG]))
    else $error("range select not taken");

  chk_cmp_gain: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_acc && apb_req.paddr == `VREF_CTRL_OFS |=>
      analog_ctrl.cmp_dac_gain_select ==
        $past(apb_req.pwdata[`VREF_FLD_CMP_LO +: 2]))
    else $error("comparator gain not taken");

  chk_conv_gain: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_acc && apb_req.paddr == `VREF_CTRL_OFS |=>
      analog_ctrl.conv_gain_select ==
        $past(apb_req.pwdata[`VREF_FLD_CONV_LO +: 2]))
    else $error("converter gain not taken");

  chk_ready_settle: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !HIGH_VDD_VARIANT && $rose(analog_ctrl.ref_enable) |=> !ref_ready)
    else $error("ready without settling");

  chk_reset_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $past(sys_rst) |-> analog_ctrl == analog_ctrl_t'(7'h00))
    else $error("control not cleared by reset");

  // bit 6 has no storage, so writing a one there must not fake readiness
  chk_ready_ignored: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !HIGH_VDD_VARIANT && wr_acc && apb_req.paddr == `VREF_CTRL_OFS &&
      !apb_req.pwdata[`VREF_BIT_ENABLE] |=> !ref_ready)
    else $error("ready set by a write");

  chk_unmapped_kept: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_acc && !addr_ok |=> $stable(analog_ctrl))
    else $error("unmapped write changed control");

  chk_unmapped_zero: assert property (
    @(posedge mclk) disable iff (sys_rst)
    apb_rsp.pready && !apb_req.pwrite && !addr_ok |->
      apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  chk_pready_pulse: assert property (
    @(posedge mclk) disable iff (sys_rst)
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held past one cycle");

  // a clear racing an event must lose, or the event would be missed
  chk_set_wins: assert property (
    @(posedge mclk) disable iff (sys_rst)
    |events |=> (cur.irq_stat & $past(events)) == $past(events))
    else $error("status event lost");

  chk_stat_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wr_acc && apb_req.paddr == `VREF_IRQ_STAT_OFS && events == 2'h0 |=>
      (cur.irq_stat & $past(apb_req.pwdata[1:0])) == 2'h0)
    else $error("status bit not cleared by one");

  cov_ready_rise: cover property (@(posedge mclk) disable iff (sys_rst)
    $rose(ref_ready));
  cov_irq: cover property (@(posedge mclk) disable iff (sys_rst)
    $rose(irq));
  cov_ctrl_read: cover property (@(posedge mclk) disable iff (sys_rst)
    rd_acc && wait_q && apb_req.paddr == `VREF_CTRL_OFS);
  cov_unmapped: cover property (@(posedge mclk) disable iff (sys_rst)
    apb_rsp.pslverr);

endmodule : vref_tsense_ctrl

// *** vref_tsense_ctrl_tb_top.sv ***
// self-checking bench for the reference and sensor register bank
`include "vref_tsense_map.svh"

module vref_tsense_ctrl_tb_top
  import vref_tsense_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int SETTLE = 4;
  localparam logic [11:0] CTRL = `VREF_CTRL_OFS;
  localparam logic [11:0] STAT = `VREF_IRQ_STAT_OFS;
  localparam logic [11:0] MASK = `VREF_IRQ_MASK_OFS;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  apb_rsp_t rsp_hv;
  analog_ctrl_t analog_ctrl;
  logic ref_ready;
  logic irq;
  logic ready_hv;
  logic irq_hv;
  int fails = 0;
  int tests_run = 0;
  int en_cyc = 0;
  logic [31:0] rd;
  logic [31:0] rd_hv;
  logic err;

  vref_tsense_ctrl #(.HIGH_VDD_VARIANT(1'b0), .SETTLE_CYC(SETTLE))
    i_vref_tsense_ctrl (.mclk(mclk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .analog_ctrl(analog_ctrl), .ref_ready(ref_ready),
    .irq(irq));
  // the always-ready variant shares the bus; its ready flag, irq and control readback are watched
  vref_tsense_ctrl #(.HIGH_VDD_VARIANT(1'b1), .SETTLE_CYC(SETTLE))
    i_vref_tsense_ctrl_hv (.mclk(mclk), .sys_rst(sys_rst),
    .apb_req(apb_req), .apb_rsp(rsp_hv), .analog_ctrl(),
    .ref_ready(ready_hv), .irq(irq_hv));

  initial forever #2 mclk = ~mclk;

  // cycles since the reference was switched on
  always @(posedge mclk) en_cyc <= analog_ctrl.ref_enable ? en_cyc + 1 : 0;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one apb transfer; waits on pready, never on a fixed count
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    for (int n = 0; n < 50 && apb_rsp.pready !== 1'b1; n++) @(posedge mclk);
    chk("pready", {31'h0, apb_rsp.pready}, 32'h1);
    rd = apb_rsp.prdata;
    rd_hv = rsp_hv.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    #1;
  endtask : wr

  task rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, rd, e);
  endtask : rdchk

  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #20000;
    fails++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("ctrl_out", 32'(analog_ctrl), 32'h0);
    chk("hv_ready", {31'h0, ready_hv}, 32'h1);
    rdchk("ctrl", CTRL, 32'h0);
    chk("hv_rb", rd_hv, 32'h40);
    $display("test reset done");
    // conversion waits belong to software
    // every gain code on both paths; bit 6 and upper bits written as ones
    for (int i = 0; i < 4; i++)
    begin
      logic [7:0] v;
      v = {2'b00, i[0], ~i[0], i[1:0], ~i[1:0]};
      wr(CTRL, {24'hFFFFFF, v | 8'h40});
      chk("fields", 32'(analog_ctrl),
        {25'h0, v[7], v[5:0]});
      rdchk("ctrl_rb", CTRL, {24'h0, v});
    end
    $display("test fields done");
    wr(CTRL, 32'h80);
    chk("ref_on", {31'h0, analog_ctrl.ref_enable}, 32'h1);
    for (int n = 0; n < 40 && ref_ready !== 1'b1; n++)
    begin
      @(posedge mclk);
      #1;
    end
    chk("settle", en_cyc, SETTLE + 1);
    rdchk("ctrl_rdy", CTRL, 32'hC0);
    rdchk("stat_rise", STAT, 32'h1);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(MASK, 32'h1);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(STAT, 32'h1);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    rdchk("stat_clr", STAT, 32'h0);
    wr(CTRL, 32'h0);
    chk("ready_off", {31'h0, ref_ready}, 32'h0);
    rdchk("stat_fall", STAT, 32'h2);
    wr(MASK, 32'h3);
    chk("irq_fall", {31'h0, irq}, 32'h1);
    chk("hv_irq", {31'h0, irq_hv}, 32'h0);
    wr(STAT, 32'h2);
    chk("irq_clr2", {31'h0, irq}, 32'h0);
    $display("test ready and irq done");
    apb(1'b1, 12'h00C, 32'hFF);
    chk("err_wr", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("err_rd", {31'h0, err}, 32'h1);
    rdchk("ctrl_kept", CTRL, 32'h0);
    $display("test unmapped done");
    // a reset in mid-run must clear every writable bit again
    wr(CTRL, 32'hBF);
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("rst_out", 32'(analog_ctrl), 32'h0);
    chk("hv_ready2", {31'h0, ready_hv}, 32'h1);
    chk("rst_irq", {31'h0, irq}, 32'h0);
    rdchk("rst_ctrl", CTRL, 32'h0);
    rdchk("rst_mask", MASK, 32'h0);
    rdchk("rst_stat", STAT, 32'h0);
    $display("test mid reset done");
    stop_test();
  end
endmodule : vref_tsense_ctrl_tb_top
